// ==== verilog/flash_status_pkg.sv ====
package flash_status_pkg;

    // ****************************************************************
    // opcodes seen on the serial link
    // ****************************************************************
    localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
    localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
    localparam logic [7:0] OP_READ_STATUS      = 8'h05;
    localparam logic [7:0] OP_RESET            = 8'hF0;
    localparam logic [7:0] RESET_CONFIRM       = 8'hD0;

    // ****************************************************************
    // status byte one field positions
    // ****************************************************************
    localparam int S1_LOCK_BIT  = 7;
    localparam int S1_ERROR_BIT = 5;
    localparam int S1_PIN_BIT   = 4;
    localparam int S1_SWP_HI    = 3;
    localparam int S1_SWP_LO    = 2;
    localparam int S1_WEL_BIT   = 1;
    localparam int S1_BUSY_BIT  = 0;

    // ****************************************************************
    // status byte two field positions
    // ****************************************************************
    localparam int S2_RESET_COMMAND_ENABLE_BIT  = 4;
    localparam int S2_SLE_BIT   = 3;
    localparam int S2_PS_BIT    = 2;
    localparam int S2_ES_BIT    = 1;
    localparam int S2_BUSY_BIT  = 0;

    // ****************************************************************
    // global protect field of the byte one write
    // ****************************************************************
    localparam int         GLOBAL_HI       = 5;
    localparam int         GLOBAL_LO       = 2;
    localparam logic [3:0] GLOBAL_PROTECT  = 4'hF;
    localparam logic [3:0] GLOBAL_UNPROT   = 4'h0;

    // ****************************************************************
    // software protection summary codes
    // ****************************************************************
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_SOME = 2'h1;
    localparam logic [1:0] SWP_ALL  = 2'h3;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_LOCK   = 1'b0;
    localparam logic RST_WEL    = 1'b0;
    localparam logic RST_RESET_COMMAND_ENABLE   = 1'b0;
    localparam logic RST_SLE    = 1'b0;
    localparam logic RST_ERROR  = 1'b0;
    localparam logic RST_FROZEN = 1'b0;

endpackage : flash_status_pkg

// ==== verilog/sync_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// two flip-flop synchroniser, one stage pair per bit
// ****************************************************************
module sync_bank #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_bank width must be at least one");
    end

    always_ff @(posedge clk_in) begin
        stage_q  <= async_in;
        sync_out <= stage_q;
    end

endmodule : sync_bank

`default_nettype wire

// ==== verilog/spi_flash_status_register.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_flash_status_register
    import flash_status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output var  logic       miso,
    output var  logic       miso_oe,
    input  wire logic       wp_n,
    input  wire logic       engine_busy,
    input  wire logic       program_suspended,
    input  wire logic       erase_suspended,
    input  wire logic       any_sector_protected,
    input  wire logic       all_sectors_protected,
    input  wire logic       op_done,
    input  wire logic       op_abort,
    input  wire logic       op_is_program_erase,
    input  wire logic       op_byte_fail,
    input  wire logic       hold_abort,
    input  wire logic       freeze_done,
    output var  logic       write_cmd_allow,
    output var  logic       sector_prot_allow,
    output var  logic       lockdown_allow,
    output var  logic       global_protect_pulse,
    output var  logic       global_unprotect_pulse,
    output var  logic       soft_reset_pulse,
    output var  logic [7:0] status_byte_one,
    output var  logic [7:0] status_byte_two
);
    import flash_status_pkg::*;

    // ****************************************************************
    // link side: bit and byte counting on the serial clock
    // ****************************************************************
    logic       start_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic       byte_par_q;
    logic [6:0] shift_q;
    logic [7:0] opcode_q;
    logic [7:0] data_q;
    logic       miso_q;
    logic [2:0] bit_now;
    logic [1:0] byte_now;
    logic [15:0] status_link;
    logic       read_active;

    // first edge of a frame restarts the counters
    assign bit_now  = start_q ? 3'h0 : bit_cnt_q;
    assign byte_now = start_q ? 2'h0 : byte_cnt_q;

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            start_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
        end
    end

    always_ff @(posedge sclk) begin
        bit_cnt_q <= bit_now + 3'h1;
        shift_q   <= {shift_q[5:0], mosi};
        if (start_q) begin
            byte_par_q <= 1'b0;
        end else if (bit_now == 3'h7) begin
            byte_par_q <= ~byte_par_q;
        end
    end

    always_ff @(posedge sclk) begin
        if (bit_now == 3'h7 && byte_now != 2'h3) begin
            byte_cnt_q <= byte_now + 2'h1;
        end else begin
            byte_cnt_q <= byte_now;
        end
    end

    // opcode and first data byte, held until the next frame
    always_ff @(posedge sclk) begin
        if (bit_now == 3'h7 && byte_now == 2'h0) begin
            opcode_q <= {shift_q, mosi};
        end
        if (bit_now == 3'h7 && byte_now == 2'h1) begin
            data_q <= {shift_q, mosi};
        end
    end

    // ****************************************************************
    // link side: status read-out
    // ****************************************************************
    sync_bank #(
        .WIDTH (16)
    ) u_status_sync (
        .clk_in   (sclk),
        .async_in ({status_byte_one, status_byte_two}),
        .sync_out (status_link)
    );

    assign read_active = !start_q && byte_cnt_q != 2'h0
                         && opcode_q == OP_READ_STATUS;

    // byte one then byte two, repeating while the clock runs
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            miso_q <= 1'b0;
        end else if (read_active) begin
            miso_q <= status_link[{byte_par_q, ~bit_cnt_q}];
        end else begin
            miso_q <= 1'b0;
        end
    end

    assign miso    = miso_q;
    assign miso_oe = !cs_n && read_active;

    // ****************************************************************
    // core side: pin synchronisers and frame end detection
    // ****************************************************************
    logic [1:0] pins_sync;
    logic       cs_seen_q;
    logic       frame_end;
    logic       wp_asserted;

    sync_bank #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk_in   (clk),
        .async_in ({cs_n, wp_n}),
        .sync_out (pins_sync)
    );

    assign wp_asserted = !pins_sync[0];

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_seen_q <= 1'b1;
        end else begin
            cs_seen_q <= pins_sync[1];
        end
    end

    // link registers are still once select has risen and synced
    assign frame_end = pins_sync[1] && !cs_seen_q;

    // ****************************************************************
    // core side: frame decode
    // ****************************************************************
    logic have_op;
    logic aligned;
    logic full_data;
    logic wr_one;
    logic wr_two;
    logic wr_enable;
    logic wr_disable;
    logic reset_cmd;
    logic wr_one_ok;
    logic wr_two_ok;
    logic lock_refused;
    logic lock_q;
    logic wel_q;

    assign have_op   = frame_end && byte_cnt_q != 2'h0;
    assign aligned   = bit_cnt_q == 3'h0;
    assign full_data = byte_cnt_q >= 2'h2;

    assign wr_one     = have_op && opcode_q == OP_WRITE_STATUS_ONE;
    assign wr_two     = have_op && opcode_q == OP_WRITE_STATUS_TWO;
    assign wr_enable  = have_op && aligned && opcode_q == OP_WRITE_ENABLE;
    assign wr_disable = have_op && aligned
                        && opcode_q == OP_WRITE_DISABLE;
    assign reset_cmd  = have_op && aligned && full_data
                        && opcode_q == OP_RESET
                        && data_q == RESET_CONFIRM;

    // pin asserted refuses a clear of the lock
    assign lock_refused = lock_q && !data_q[S1_LOCK_BIT]
                          && wp_asserted;
    assign wr_one_ok = wr_one && wel_q && aligned && full_data
                       && !lock_refused;
    assign wr_two_ok = wr_two && wel_q && aligned && full_data;

    // ****************************************************************
    // core side: control bits
    // ****************************************************************
    logic reset_command_enable_q;
    logic sle_q;
    logic frozen_q;
    logic error_q;
    logic rst_honoured;

    assign rst_honoured = reset_cmd && reset_command_enable_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            lock_q <= RST_LOCK;
        end else if (wr_one_ok) begin
            lock_q <= data_q[S1_LOCK_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wel_q <= RST_WEL;
        end else if (wr_enable) begin
            wel_q <= 1'b1;
        end else if (wr_disable || rst_honoured) begin
            wel_q <= 1'b0;
        end else if (wr_one || wr_two) begin
            wel_q <= 1'b0;
        end else if (op_done || op_abort || hold_abort) begin
            wel_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reset_command_enable_q <= RST_RESET_COMMAND_ENABLE;
        end else if (wr_two_ok) begin
            reset_command_enable_q <= data_q[S2_RESET_COMMAND_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            frozen_q <= RST_FROZEN;
        end else if (freeze_done) begin
            frozen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sle_q <= RST_SLE;
        end else if (freeze_done || frozen_q) begin
            sle_q <= 1'b0;
        end else if (wr_two_ok) begin
            sle_q <= data_q[S2_SLE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            error_q <= RST_ERROR;
        end else if (op_done && op_is_program_erase) begin
            error_q <= op_byte_fail;
        end else if (op_abort && op_is_program_erase) begin
            error_q <= 1'b0;
        end
    end

    // ****************************************************************
    // core side: pulses to the protection and reset logic
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            global_protect_pulse   <= 1'b0;
            global_unprotect_pulse <= 1'b0;
        end else begin
            global_protect_pulse   <= wr_one_ok && !lock_q
                && data_q[GLOBAL_HI:GLOBAL_LO] == GLOBAL_PROTECT;
            global_unprotect_pulse <= wr_one_ok && !lock_q
                && data_q[GLOBAL_HI:GLOBAL_LO] == GLOBAL_UNPROT;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= rst_honoured;
        end
    end

    // ****************************************************************
    // core side: permissions for the command engines
    // ****************************************************************
    assign write_cmd_allow   = wel_q;
    assign sector_prot_allow = wel_q && !lock_q;
    assign lockdown_allow    = wel_q && sle_q;

    // ****************************************************************
    // core side: status bytes
    // ****************************************************************
    logic [1:0] engine_sync;
    logic [2:0] flags_sync;
    logic [1:0] swp_code;

    sync_bank #(
        .WIDTH (5)
    ) u_flag_sync (
        .clk_in   (clk),
        .async_in ({any_sector_protected, all_sectors_protected,
                    engine_busy, program_suspended, erase_suspended}),
        .sync_out ({engine_sync, flags_sync})
    );

    always_comb begin
        if (engine_sync[0]) begin
            swp_code = SWP_ALL;
        end else if (engine_sync[1]) begin
            swp_code = SWP_SOME;
        end else begin
            swp_code = SWP_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_byte_one <= 8'h00;
        end else begin
            status_byte_one                      <= 8'h00;
            status_byte_one[S1_LOCK_BIT]         <= lock_q;
            status_byte_one[S1_ERROR_BIT]        <= error_q;
            status_byte_one[S1_PIN_BIT]          <= wp_asserted;
            status_byte_one[S1_SWP_HI:S1_SWP_LO] <= swp_code;
            status_byte_one[S1_WEL_BIT]          <= wel_q;
            status_byte_one[S1_BUSY_BIT]         <= flags_sync[2];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_byte_two <= 8'h00;
        end else begin
            status_byte_two              <= 8'h00;
            status_byte_two[S2_RESET_COMMAND_ENABLE_BIT] <= reset_command_enable_q;
            status_byte_two[S2_SLE_BIT]  <= sle_q;
            status_byte_two[S2_PS_BIT]   <= flags_sync[1];
            status_byte_two[S2_ES_BIT]   <= flags_sync[0];
            status_byte_two[S2_BUSY_BIT] <= flags_sync[2];
        end
    end

endmodule : spi_flash_status_register

`default_nettype wire

// ==== verif/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****
// mode 0 host, clock runs only inside a frame
// ****
module spi_host_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic xfer(input logic [23:0] d, input int n,
                        output logic [23:0] r);
        r = 24'h0;
        #3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = d[i];
            #32 sclk = 1'b1;
            r = {r[22:0], miso};
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        mosi = ~mosi;
        #100;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ==== verif/spi_flash_status_register_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_flash_status_checker
    import flash_status_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       wp_n,
    input wire logic       engine_busy,
    input wire logic       op_done,
    input wire logic       op_abort,
    input wire logic       op_is_program_erase,
    input wire logic       op_byte_fail,
    input wire logic       hold_abort,
    input wire logic       write_cmd_allow,
    input wire logic       sector_prot_allow,
    input wire logic       lockdown_allow,
    input wire logic       global_protect_pulse,
    input wire logic       global_unprotect_pulse,
    input wire logic       soft_reset_pulse,
    input wire logic [7:0] status_byte_one,
    input wire logic [7:0] status_byte_two
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_B2_RSVD: assert property (
        status_byte_two[7:5] == 3'h0) else $error("byte two reserved set");
    AST_SWP_CODE: assert property (
        status_byte_one[S1_SWP_HI:S1_SWP_LO] != 2'h2)
        else $error("bad protection summary");
    AST_WEL_SHOWN: assert property (
        status_byte_one[S1_WEL_BIT] == $past(write_cmd_allow))
        else $error("latch bit differs from allow");
    AST_SECT_LOCK: assert property (
        sector_prot_allow |=> !status_byte_one[S1_LOCK_BIT]
        && status_byte_one[S1_WEL_BIT]) else $error("sector allow locked");
    AST_LOCKDOWN: assert property (
        lockdown_allow |=> status_byte_two[S2_SLE_BIT])
        else $error("lockdown allowed with enable 0");
    AST_GLOBAL: assert property (
        global_protect_pulse || global_unprotect_pulse
        |-> !status_byte_one[S1_LOCK_BIT])
        else $error("global op while locked");
    AST_SOFT_RST: assert property (
        soft_reset_pulse |-> status_byte_two[S2_RESET_COMMAND_ENABLE_BIT]
        ##1 !soft_reset_pulse) else $error("reset not gated");
    AST_ERR_SET: assert property (
        op_done && op_is_program_erase && op_byte_fail
        |-> ##2 status_byte_one[S1_ERROR_BIT]) else $error("error not set");
    AST_ERR_ABORT: assert property (
        op_abort && op_is_program_erase
        |-> ##2 !status_byte_one[S1_ERROR_BIT]) else $error("abort error");
    AST_WEL_CLR: assert property (
        op_done || op_abort || hold_abort
        |-> ##2 !status_byte_one[S1_WEL_BIT]) else $error("latch kept");
    AST_PIN: assert property (
        $stable(wp_n) [*5] |-> status_byte_one[S1_PIN_BIT] == !wp_n)
        else $error("pin bit wrong");
    AST_BUSY: assert property (
        $stable(engine_busy) [*5]
        |-> status_byte_one[S1_BUSY_BIT] == engine_busy
        && status_byte_two[S2_BUSY_BIT] == engine_busy)
        else $error("busy bit wrong");

    cover property (global_protect_pulse);
    cover property (global_unprotect_pulse);
    cover property (soft_reset_pulse);
    cover property (op_done && op_byte_fail);
endmodule : spi_flash_status_checker

bind spi_flash_status_register spi_flash_status_checker u_chk (
    .clk, .srst, .wp_n, .engine_busy, .op_done, .op_abort,
    .op_is_program_erase, .op_byte_fail, .hold_abort, .write_cmd_allow,
    .sector_prot_allow, .lockdown_allow, .global_protect_pulse,
    .global_unprotect_pulse, .soft_reset_pulse, .status_byte_one,
    .status_byte_two
);

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import flash_status_pkg::*;
    logic        clk, srst, wp_n, sclk, cs_n, mosi, miso;
    logic        wca, spa, lda, gpp, gup, srp, oe;
    logic        oe_seen = 1'b0;
    logic [4:0]  fl;
    logic [5:0]  ev;
    logic [7:0]  b1, b2, e1;
    logic [7:0]  n_gp = 8'h00, n_gu = 8'h00, n_rst = 8'h00;
    logic [23:0] r;
    int          n_fail = 0, checks_done = 0, cyc = 0;

    spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));

    spi_flash_status_register u_dut (
        .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(oe), .wp_n(wp_n), .engine_busy(fl[4]),
        .program_suspended(fl[3]), .erase_suspended(fl[2]),
        .any_sector_protected(fl[1]), .all_sectors_protected(fl[0]),
        .op_done(ev[5]), .op_abort(ev[4]), .op_is_program_erase(ev[3]),
        .op_byte_fail(ev[2]), .hold_abort(ev[1]), .freeze_done(ev[0]),
        .write_cmd_allow(wca), .sector_prot_allow(spa),
        .lockdown_allow(lda), .global_protect_pulse(gpp),
        .global_unprotect_pulse(gup), .soft_reset_pulse(srp),
        .status_byte_one(b1), .status_byte_two(b2));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (gpp) n_gp <= n_gp + 8'h01;
        if (gup) n_gu <= n_gu + 8'h01;
        if (srp) n_rst <= n_rst + 8'h01;
        if (oe) oe_seen <= 1'b1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic st(input logic [7:0] x1, input logic [7:0] x2);
        repeat (6) @(negedge clk);
        chk(b1, x1);
        chk(b2, x2);
    endtask : st

    task automatic cmd(input logic [7:0] op);
        u_host.xfer({16'h0, op}, 8, r);
    endtask : cmd

    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        u_host.xfer({8'h0, op, d}, 16, r);
    endtask : wr

    task automatic pulse(input logic [5:0] v);
        @(posedge clk) ev <= v;
        @(posedge clk) ev <= 6'h00;
        repeat (3) @(posedge clk);
    endtask : pulse

    initial begin
        fl = 5'h00;
        ev = 6'h00;
        wp_n = 1'b1;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        st(8'h00, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            fl <= {3'b111, i > 0, i == 2};
            wp_n <= (i != 1);
            e1 = {3'h0, i == 1, i == 2, i > 0, 2'h1};
            st(e1, 8'h07);
            u_host.xfer({OP_READ_STATUS, 16'h0}, 24, r);
            chk(r[15:8], e1);
            chk(r[7:0], 8'h07);
        end
        chk(8'(oe_seen), 8'h01);
        chk(8'(oe), 8'h00);
        @(posedge clk);
        fl <= 5'h00;
        wp_n <= 1'b1;
        cmd(OP_WRITE_ENABLE);
        chk(8'(wca), 8'h01);
        wr(OP_WRITE_STATUS_TWO, 8'hFF);
        st(8'h00, 8'h18);
        wr(OP_WRITE_STATUS_TWO, 8'h00);
        st(8'h00, 8'h18);
        cmd(OP_WRITE_ENABLE);
        chk(8'(lda), 8'h01);
        u_host.xfer({8'h0, OP_RESET, RESET_CONFIRM}, 16, r);
        chk(n_rst, 8'h01);
        st(8'h00, 8'h18);
        cmd(OP_WRITE_ENABLE);
        wr(OP_WRITE_STATUS_ONE, 8'hFF);
        chk(n_gp, 8'h01);
        st(8'h80, 8'h18);
        cmd(OP_WRITE_ENABLE);
        chk(8'(spa), 8'h00);
        @(posedge clk) wp_n <= 1'b0;
        wr(OP_WRITE_STATUS_ONE, 8'h00);
        st(8'h90, 8'h18);
        cmd(OP_WRITE_ENABLE);
        u_host.xfer(24'h0, 5, r);
        chk(8'(wca), 8'h01);
        u_host.xfer({12'h0, OP_WRITE_STATUS_ONE, 4'h0}, 12, r);
        st(8'h90, 8'h18);
        @(posedge clk) wp_n <= 1'b1;
        cmd(OP_WRITE_ENABLE);
        wr(OP_WRITE_STATUS_ONE, 8'h00);
        chk(n_gu, 8'h00);
        st(8'h00, 8'h18);
        cmd(OP_WRITE_ENABLE);
        chk(8'(spa), 8'h01);
        cmd(OP_WRITE_DISABLE);
        chk(8'(wca), 8'h00);
        cmd(OP_WRITE_ENABLE);
        wr(OP_WRITE_STATUS_ONE, 8'h00);
        chk(n_gu, 8'h01);
        cmd(OP_WRITE_ENABLE);
        pulse(6'h2C);
        st(8'h20, 8'h18);
        pulse(6'h18);
        st(8'h00, 8'h18);
        pulse(6'h2C);
        pulse(6'h28);
        st(8'h00, 8'h18);
        cmd(OP_WRITE_ENABLE);
        pulse(6'h02);
        chk(8'(wca), 8'h00);
        pulse(6'h01);
        st(8'h00, 8'h10);
        cmd(OP_WRITE_ENABLE);
        wr(OP_WRITE_STATUS_TWO, 8'h18);
        st(8'h00, 8'h10);
        cmd(OP_WRITE_ENABLE);
        wr(OP_WRITE_STATUS_TWO, 8'h00);
        u_host.xfer({8'h0, OP_RESET, RESET_CONFIRM}, 16, r);
        chk(n_rst, 8'h01);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
